/* File: rtl/epa_partner_ability.sv */
// Operation
// - Read-only register at 0x1D4, writes ignored
// - Bits 31:16 padding; serial view 16 bits
// - Next page bit 15 reads zero
// - Acknowledge bit 14 reads one
// - Remote fault bit 13 reads zero
// - 100BASE-T4 bit 9 reads zero
// - Selector bits 4:0 read 00001
// - Pause none->none, symmetric->symmetric
// - Asym->both set; both->asym only
// - Pin equals polarity: full duplex by speed
// - Pin differs polarity: half duplex by speed
// - Bits 8:5 also depend on negotiation success
// - Straps captured once at reset release
// - Local pause reset value from flow strap
// - No common ability bits means negotiation failed
module epa_partner_ability (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [epa_pkg::EPA_ADDR_W-1:0] i_reg_addr,
    input wire logic [15:0] i_local_advertisement_register,
    input wire logic i_duplex_pin,
    input wire logic i_duplex_pol_strap,
    input wire logic i_speed_strap,
    input wire logic i_manual_flow_control_strap,
    output logic [epa_pkg::EPA_DATA_W-1:0] o_reg_rdata,
    output logic [epa_pkg::EPA_SERIAL_W-1:0] o_reg_rdata_serial,
    output logic o_reg_rvalid,
    output logic o_partner_an_able,
    output logic o_local_sym_pause_reset,
    output logic o_straps_valid
);
    import epa_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Speed and duplex ability offered by the emulated partner
    // Pin level is live; polarity and speed are straps
    function automatic logic [3:0] default_ability(
        input logic duplex_level,
        input logic polarity,
        input logic fast
    );
        logic match;
        logic [3:0] code;
        match = (duplex_level == polarity);
        code = EPA_ABIL_NONE;
        case ({match, fast})
            2'h3: begin
                // Full duplex at 100 Mb/s
                code = EPA_ABIL_100_FD;
            end
            2'h2: begin
                // Full duplex at 10 Mb/s
                code = EPA_ABIL_10_FD;
            end
            2'h1: begin
                // Half duplex at 100 Mb/s
                code = EPA_ABIL_100_HD;
            end
            2'h0: begin
                // Half duplex at 10 Mb/s
                code = EPA_ABIL_10_HD;
            end
            default: begin
                code = EPA_ABIL_NONE;
            end
        endcase
        return code;
    endfunction

    // Shared ability check between local and partner
    // No shared bit means negotiation failed
    function automatic logic abilities_overlap(
        input logic [3:0] own_abil,
        input logic [3:0] peer_abil
    );
        logic [3:0] common;
        common = own_abil & peer_abil;
        return |common;
    endfunction

    // Partner pause answer as {asymmetric, symmetric}
    // The partner always grants what the local side asks
    function automatic logic [1:0] partner_pause(
        input logic local_asym_bit,
        input logic local_sym_bit
    );
        logic [1:0] pause;
        pause = 2'h0;
        case ({local_asym_bit, local_sym_bit})
            2'h0: begin
                // No flow control: none offered
                pause = 2'h0;
            end
            2'h1: begin
                // Symmetric asked: symmetric offered
                pause = 2'h1;
            end
            2'h2: begin
                // Asymmetric towards switch: both offered
                pause = 2'h3;
            end
            2'h3: begin
                // Asymmetric towards MAC: asymmetric only
                pause = 2'h2;
            end
            default: begin
                pause = 2'h0;
            end
        endcase
        return pause;
    endfunction

    // Sixteen-bit partner ability word
    // Fixed fields, then pause, ability and selector
    function automatic logic [EPA_SERIAL_W-1:0] partner_word_of(
        input logic [1:0] pause,
        input logic [3:0] abil
    );
        logic [EPA_SERIAL_W-1:0] word;
        word = '0;
        word[EPA_NEXT_PAGE_BIT] = EPA_NEXT_PAGE_VAL;
        word[EPA_ACK_BIT] = EPA_ACK_VAL;
        word[EPA_REMOTE_FAULT_BIT] = EPA_REMOTE_FAULT_VAL;
        word[EPA_RSVD12_BIT] = EPA_RSVD_VAL;
        word[EPA_ASYM_PAUSE_BIT] = pause[1];
        word[EPA_SYM_PAUSE_BIT] = pause[0];
        word[EPA_T4_BIT] = EPA_T4_VAL;
        word[EPA_ABIL_MSB:EPA_ABIL_LSB] = abil;
        word[EPA_SEL_MSB:EPA_SEL_LSB] = EPA_SEL_8023;
        return word;
    endfunction

    // Thirty-two-bit answer for one taken read
    // Upper half is padding; unmapped offsets read zero
    function automatic logic [EPA_DATA_W-1:0] read_word(
        input logic hit,
        input logic [EPA_SERIAL_W-1:0] word
    );
        logic [EPA_DATA_W-1:0] data;
        data = EPA_RDATA_RST;
        if (hit) begin
            data = {16'h0000, word};
        end
        return data;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Strap capture state
    logic captured;
    logic duplex_pol;
    logic speed_sel;
    logic local_sym_rst;
    logic next_captured;
    logic next_duplex_pol;
    logic next_speed_sel;
    logic next_local_sym_rst;

    // Capture straps on the first edge after reset release only
    // Later strap changes are ignored until the next reset
    always_comb begin
        next_captured = 1'h1;
        next_duplex_pol = duplex_pol;
        next_speed_sel = speed_sel;
        next_local_sym_rst = local_sym_rst;
        if (!captured) begin
            // Duplex polarity and speed for the partner
            next_duplex_pol = i_duplex_pol_strap;
            next_speed_sel = i_speed_strap;
            // Low flow control strap asks for symmetric pause
            next_local_sym_rst = ~i_manual_flow_control_strap;
        end
    end

    // Strap registers; cleared while reset is low
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Nothing captured yet
            captured <= 1'h0;
            duplex_pol <= EPA_STRAP_RST;
            speed_sel <= EPA_STRAP_RST;
            local_sym_rst <= EPA_STRAP_RST;
        end else begin
            // Captured values hold once taken
            captured <= next_captured;
            duplex_pol <= next_duplex_pol;
            speed_sel <= next_speed_sel;
            local_sym_rst <= next_local_sym_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Emulated partner word

    // Live local advertisement fields
    logic local_sym;
    logic local_asym;
    logic [3:0] local_abil;

    // Partner answer pieces
    logic [3:0] default_abil;
    logic an_ok;
    logic [1:0] pause_bits;
    logic [3:0] partner_abil;
    logic [15:0] partner_word;

    // Split the live local advertisement into fields
    // Bits outside pause and ability are not used here
    assign local_sym = i_local_advertisement_register[EPA_SYM_PAUSE_BIT];
    assign local_asym = i_local_advertisement_register[EPA_ASYM_PAUSE_BIT];
    assign local_abil = i_local_advertisement_register[EPA_ABIL_MSB:EPA_ABIL_LSB];

    // Default ability from the live pin and captured straps
    // A pin change shows on the next read without reset
    assign default_abil = default_ability(i_duplex_pin, duplex_pol, speed_sel);

    // Negotiation fails with no shared ability bit
    assign an_ok = abilities_overlap(local_abil, default_abil);

    // Pause answer follows the local request
    assign pause_bits = partner_pause(local_asym, local_sym);

    // Failed negotiation leaves no speed or duplex bit
    assign partner_abil = an_ok ? default_abil : EPA_ABIL_NONE;

    // Assemble the 16-bit partner view
    // Rebuilt every cycle; only a taken read registers it
    assign partner_word = partner_word_of(pause_bits, partner_abil);

    ////////////////////////////////////////////////////////////////////
    // Read port; writes are never decoded

    // Request decode
    logic read_taken;
    logic addr_hit;

    // Registered answer and status
    logic [EPA_DATA_W-1:0] rdata;
    logic rvalid;
    logic an_able;

    // Next values
    logic [EPA_DATA_W-1:0] next_rdata;
    logic next_rvalid;
    logic next_an_able;

    // A read is taken only with no write beside it
    // Write with read is dropped without notice
    assign read_taken = i_reg_rd & ~i_reg_wr;

    // Only the partner ability offset maps
    assign addr_hit = (i_reg_addr == EPA_PARTNER_ABILITY_OFS);

    // Next read data, answer strobe and negotiation flag
    always_comb begin
        next_rvalid = read_taken;
        next_rdata = rdata;
        next_an_able = an_ok;
        // Data holds until the next taken read
        if (read_taken) begin
            next_rdata = read_word(addr_hit, partner_word);
        end
    end

    // Read registers; reads change no other state
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // No answer pending after reset
            rdata <= EPA_RDATA_RST;
            rvalid <= 1'h0;
            an_able <= 1'h0;
        end else begin
            // Strobe lasts one cycle; data holds
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            an_able <= next_an_able;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop

    // Read answer
    assign o_reg_rdata = rdata;
    // Serial view is the low half
    assign o_reg_rdata_serial = rdata[EPA_SERIAL_W-1:0];
    // One-cycle answer strobe
    assign o_reg_rvalid = rvalid;

    // Negotiation outcome, lagging one cycle
    assign o_partner_an_able = an_able;

    // Reset value for the local symmetric pause bit
    assign o_local_sym_pause_reset = local_sym_rst;
    // Captured once per reset
    assign o_straps_valid = captured;
endmodule

/* File: rtl/epa_pkg.sv */
package epa_pkg;
    // Register map
    localparam int EPA_ADDR_W = 12;
    localparam logic [EPA_ADDR_W-1:0] EPA_PARTNER_ABILITY_OFS = 12'h1d4;
    localparam int EPA_DATA_W = 32;
    localparam int EPA_SERIAL_W = 16;

    // Field positions of the partner ability word
    localparam int EPA_NEXT_PAGE_BIT = 15;
    localparam int EPA_ACK_BIT = 14;
    localparam int EPA_REMOTE_FAULT_BIT = 13;
    localparam int EPA_RSVD12_BIT = 12;
    localparam int EPA_ASYM_PAUSE_BIT = 11;
    localparam int EPA_SYM_PAUSE_BIT = 10;
    localparam int EPA_T4_BIT = 9;
    localparam int EPA_ABIL_MSB = 8;
    localparam int EPA_ABIL_LSB = 5;
    localparam int EPA_SEL_MSB = 4;
    localparam int EPA_SEL_LSB = 0;

    // Fixed field values
    localparam logic EPA_NEXT_PAGE_VAL = 1'h0;
    localparam logic EPA_ACK_VAL = 1'h1;
    localparam logic EPA_REMOTE_FAULT_VAL = 1'h0;
    localparam logic EPA_RSVD_VAL = 1'h0;
    localparam logic EPA_T4_VAL = 1'h0;
    localparam logic [4:0] EPA_SEL_8023 = 5'h01;

    // Speed and duplex ability codes, bits 8..5
    localparam logic [3:0] EPA_ABIL_10_FD = 4'h2;
    localparam logic [3:0] EPA_ABIL_100_FD = 4'h8;
    localparam logic [3:0] EPA_ABIL_10_HD = 4'h1;
    localparam logic [3:0] EPA_ABIL_100_HD = 4'h4;
    localparam logic [3:0] EPA_ABIL_NONE = 4'h0;

    // Reset values
    localparam logic [EPA_DATA_W-1:0] EPA_RDATA_RST = 32'h0000_0000;
    localparam logic EPA_STRAP_RST = 1'h0;
endpackage

/* File: tb/epa_properties.sv */
// Port-level checks of the partner ability read path
module epa_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [epa_pkg::EPA_ADDR_W-1:0] i_reg_addr,
    input wire logic [15:0] i_local_advertisement_register,
    input wire logic [epa_pkg::EPA_DATA_W-1:0] o_reg_rdata,
    input wire logic [epa_pkg::EPA_SERIAL_W-1:0] o_reg_rdata_serial,
    input wire logic o_reg_rvalid,
    input wire logic o_straps_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import epa_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_hit;
        o_reg_rvalid && $past(i_reg_addr) == EPA_PARTNER_ABILITY_OFS;
    endsequence
    property p_ans; i_reg_rd && !i_reg_wr |=> o_reg_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_wr; !i_reg_rd || i_reg_wr |=> !o_reg_rvalid; endproperty
    a_wr: assert property (p_wr) else $error("answer without read");
    property p_pad; o_reg_rvalid |-> o_reg_rdata[31:16] == 16'h0000; endproperty
    a_pad: assert property (p_pad) else $error("upper half not zero");
    property p_ser; o_reg_rdata_serial == o_reg_rdata[15:0]; endproperty
    a_ser: assert property (p_ser) else $error("serial view differs");
    property p_fix; s_hit |-> o_reg_rdata[15:12] == 4'h4; endproperty
    a_fix: assert property (p_fix) else $error("fixed top bits wrong");
    property p_sel; s_hit |-> !o_reg_rdata[9] && o_reg_rdata[4:0] == 5'h01; endproperty
    a_sel: assert property (p_sel) else $error("t4 or selector wrong");
    property p_pause;
        s_hit |-> o_reg_rdata[11:10] == {$past(i_local_advertisement_register[11]),
            ^$past(i_local_advertisement_register[11:10])};
    endproperty
    a_pause: assert property (p_pause) else $error("pause mirror wrong");
    property p_hold; !o_reg_rvalid |-> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("data changed without read");
    property p_strap; o_straps_valid |=> o_straps_valid; endproperty
    a_strap: assert property (p_strap) else $error("strap capture lost");
endmodule
bind epa_partner_ability epa_checker u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_local_advertisement_register(i_local_advertisement_register),
    .o_reg_rdata(o_reg_rdata), .o_reg_rdata_serial(o_reg_rdata_serial),
    .o_reg_rvalid(o_reg_rvalid), .o_straps_valid(o_straps_valid));

/* File: tb/test_emulated_partner_ability.sv */
module test_emulated_partner_ability;
    timeunit 1ns;
    timeprecision 1ps;
    import epa_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, pin = 1'b0;
    logic pol = 1'b0, spd = 1'b0, mfc = 1'b0, rv, able, lsp, sv;
    logic [11:0] addr = 12'h000;
    logic [15:0] adv = 16'h0000, ser;
    logic [31:0] rdata;
    logic [3:0] d;
    int err_total = 0, n_tests = 0;
    epa_partner_ability dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_rd(rd),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_local_advertisement_register(adv),
        .i_duplex_pin(pin), .i_duplex_pol_strap(pol), .i_speed_strap(spd),
        .i_manual_flow_control_strap(mfc), .o_reg_rdata(rdata), .o_reg_rdata_serial(ser),
        .o_reg_rvalid(rv), .o_partner_an_able(able), .o_local_sym_pause_reset(lsp),
        .o_straps_valid(sv));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One read, answer checked at the falling edge half a cycle after the taking edge
    task rd_chk(input logic [11:0] a, input logic [31:0] e);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({31'h0, rv}, 32'h1);
        chk(rdata, e);
        chk({16'h0, ser}, e & 32'h0000ffff);
    endtask
    task tally_and_finish;
        $display("errors %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Strap sets, pin levels, pause codes and ability overlaps
    initial begin
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            rst_b = 1'b0;
            {mfc, pol, spd} = c[2:0];
            repeat (5) @(negedge clk);
            rst_b = 1'b1;
            @(negedge clk);
            {mfc, pol, spd} = ~c[2:0];
            @(negedge clk);
            chk({31'h0, sv}, 32'h1);
            chk({31'h0, lsp}, {31'h0, ~c[2]});
            for (int k = 0; k < 16; k++) begin
                pin = k[3];
                adv = {4'h0, k[1:0], 1'b0, k[2] ? 4'h5 : 4'ha, 5'h01};
                d = (pin == c[1]) ? (c[0] ? 4'h8 : 4'h2) : (c[0] ? 4'h4 : 4'h1);
                @(negedge clk);
                chk({31'h0, able}, {31'h0, |(adv[8:5] & d)});
                if ((adv[8:5] & d) == 4'h0) d = 4'h0;
                rd_chk(EPA_PARTNER_ABILITY_OFS, {16'h0, 4'h4, k[1], ^k[1:0], 1'b0, d, 5'h01});
            end
        end
        @(negedge clk);
        {rd, wr, addr} = {2'b11, EPA_PARTNER_ABILITY_OFS};
        @(negedge clk);
        {rd, wr} = 2'b00;
        chk({31'h0, rv}, 32'h0);
        @(negedge clk);
        rd_chk(12'h1d0, 32'h0);
        tally_and_finish();
    end
    // Watchdog well beyond the expected run
    initial begin
        #50us;
        err_total++;
        tally_and_finish();
    end
endmodule
